// *** sod_top.sv ***
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module sod_top
(
   // Clock and resets
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        POR,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Option outputs
   output logic             WATCHDOG_ENABLE,
   output logic             WATCHDOG_LONG_TIMEOUT,
   output logic             WATCHDOG_CLOCK_SELECT,
   output logic             STOP_PERMIT,
   output logic             DEBUG_PIN_ENABLE,
   output logic             RESET_PIN_ENABLE,
   output logic             RESET_PIN_PULLUP
);
   import sod_pkg::*;

   logic       wr_pend_reg;
   logic [3:0] wr_addr_reg;
   logic [7:0] prim_q;
   logic       prim_locked;
   logic       sec_q;
   logic       rstpin_q;
   logic       addr_ph;
   logic       wr_prim;
   logic       wr_sec;
   logic [7:0] rd_next;

   function automatic logic hit(input logic [3:0] a, input logic [31:0] o);
      hit = (a == o[SOD_ADDR_MSB:0]);
   endfunction

   assign addr_ph = HSEL && HREADY &&
                    (HTRANS == SOD_HTRANS_NONSEQ || HTRANS == SOD_HTRANS_SEQ);

   // Capture write address phase; data follows next cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 4'h0;
      end else begin
         // Unmapped writes must not alias onto the options
         wr_pend_reg <= addr_ph && HWRITE && !(|HADDR[31:SOD_ADDR_MSB+1]);
         if (addr_ph) begin
            wr_addr_reg <= HADDR[SOD_ADDR_MSB:0];
         end
      end
   end

   // Identity registers get no write strobe at all
   assign wr_prim = wr_pend_reg &&
                    hit(wr_addr_reg, SOD_OFS_PRIMARY);
   assign wr_sec  = wr_pend_reg && hit(wr_addr_reg, SOD_OFS_SECONDARY);

   sod_once_reg #(.W(8), .RST(SOD_PRIMARY_RST)) u_prim (
      .clk    (CLK),
      .rst    (RST),
      .wr     (wr_prim),
      .wdata  (HWDATA[7:0] & SOD_PRIMARY_MASK),
      .q      (prim_q),
      .locked (prim_locked)
   );

   sod_once_reg #(.W(1), .RST({7'h00, SOD_WCLK_RST})) u_sec (
      .clk    (CLK),
      .rst    (RST),
      .wr     (wr_sec),
      .wdata  (HWDATA[0]),
      .q      (sec_q),
      .locked ()
   );

   // Lock follows the full reset, value survives all but power-on
   sod_rstpin_hold u_rstpin (
      .clk   (CLK),
      .por   (POR),
      .load  (wr_prim && !prim_locked),
      .wdata (HWDATA[SOD_BIT_RSTPIN]),
      .q     (rstpin_q)
   );

   always_comb begin
      rd_next = 8'h00;
      if (hit(HADDR[SOD_ADDR_MSB:0], SOD_OFS_PRIMARY)) begin
         rd_next = prim_q & SOD_PRIMARY_MASK;
         rd_next[SOD_BIT_RSTPIN] = rstpin_q;
      end else if (hit(HADDR[SOD_ADDR_MSB:0], SOD_OFS_SECONDARY)) begin
         rd_next = {7'h00, sec_q};
      end else if (hit(HADDR[SOD_ADDR_MSB:0], SOD_OFS_ID_HIGH)) begin
         rd_next = {SOD_REVISION, SOD_PART_NUMBER[11:8]};
      end else if (hit(HADDR[SOD_ADDR_MSB:0], SOD_OFS_ID_LOW)) begin
         rd_next = SOD_PART_NUMBER[7:0];
      end
      if (|HADDR[31:SOD_ADDR_MSB+1]) begin
         rd_next = 8'h00;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (addr_ph && !HWRITE) begin
         HRDATA <= {24'h00_0000, rd_next};
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // Registered copies of the controls
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         WATCHDOG_ENABLE       <= SOD_PRIMARY_RST[SOD_BIT_WDOG_EN];
         WATCHDOG_LONG_TIMEOUT <= SOD_PRIMARY_RST[SOD_BIT_WDOG_LONG];
         STOP_PERMIT           <= SOD_PRIMARY_RST[SOD_BIT_STOP];
         DEBUG_PIN_ENABLE      <= SOD_PRIMARY_RST[SOD_BIT_DEBUG];
         WATCHDOG_CLOCK_SELECT <= SOD_WCLK_RST;
      end else begin
         WATCHDOG_ENABLE       <= prim_q[SOD_BIT_WDOG_EN];
         WATCHDOG_LONG_TIMEOUT <= prim_q[SOD_BIT_WDOG_LONG];
         STOP_PERMIT           <= prim_q[SOD_BIT_STOP];
         DEBUG_PIN_ENABLE      <= prim_q[SOD_BIT_DEBUG];
         WATCHDOG_CLOCK_SELECT <= sec_q;
      end
   end

   // Only power-on clears these; other resets keep the pin setting
   always_ff @(posedge CLK or posedge POR) begin
      if (POR) begin
         RESET_PIN_ENABLE <= 1'b0;
         RESET_PIN_PULLUP <= 1'b0;
      end else begin
         RESET_PIN_ENABLE <= rstpin_q;
         RESET_PIN_PULLUP <= rstpin_q;
      end
   end
endmodule

// *** sod_pkg.sv ***
// Operation
// - Primary options accept first write only
// - Bit 7 enables watchdog, resets to one
// - Bit 6 selects long watchdog timeout
// - Bit 5 permits stop, else illegal-opcode reset
// - Bit 1 routes pin to debug function
// - Bit 0 makes pin reset input, pullup
// - Reset-pin enable cleared by power-on only
// - Bit 4 reserved, stored, no effect
// - Secondary options hold write-once watchdog clock
// - High identity bits 7:4 give revision
// - Fixed twelve-bit part number across identity registers
package sod_pkg;
   localparam logic [31:0] SOD_OFS_PRIMARY   = 32'h0000_0000;
   localparam logic [31:0] SOD_OFS_SECONDARY = 32'h0000_0004;
   localparam logic [31:0] SOD_OFS_ID_HIGH   = 32'h0000_0008;
   localparam logic [31:0] SOD_OFS_ID_LOW    = 32'h0000_000C;
   localparam logic [3:0]  SOD_ADDR_MSB      = 4'h3;
   localparam int          SOD_BIT_WDOG_EN   = 7;
   localparam int          SOD_BIT_WDOG_LONG = 6;
   localparam int          SOD_BIT_STOP      = 5;
   localparam int          SOD_BIT_RSVD      = 4;
   localparam int          SOD_BIT_DEBUG     = 1;
   localparam int          SOD_BIT_RSTPIN    = 0;
   // Bits 3:2 are unimplemented
   localparam logic [7:0]  SOD_PRIMARY_MASK  = 8'hF3;
   localparam logic [7:0]  SOD_PRIMARY_RST   = 8'hD2;
   localparam logic        SOD_WCLK_RST      = 1'h0;
   // Arbitrary neutral identity values
   localparam logic [3:0]  SOD_REVISION      = 4'h0;
   localparam logic [11:0] SOD_PART_NUMBER   = 12'hA5C;
   localparam logic [1:0]  SOD_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  SOD_HTRANS_SEQ    = 2'h3;
endpackage

// *** sod_once_reg.sv ***
`timescale 1ns/1ps
module sod_once_reg #(
   parameter int         W   = 8,
   parameter logic [7:0] RST = 8'h00
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Write side
   input  wire logic         wr,
   input  wire logic [W-1:0] wdata,
   // Stored value
   output logic      [W-1:0] q,
   output logic              locked
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= RST[W-1:0];
      end else if (wr && !locked) begin
         q <= wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         locked <= 1'b0;
      end else if (wr) begin
         locked <= 1'b1;
      end
   end
endmodule

// *** sod_rstpin_hold.sv ***
`timescale 1ns/1ps
// Sits on power-on reset only, so ordinary resets leave it alone
module sod_rstpin_hold (
   // Clock and power-on reset
   input  wire logic clk,
   input  wire logic por,
   // Load from the options write
   input  wire logic load,
   input  wire logic wdata,
   // Stored bit
   output logic      q
);
   always_ff @(posedge clk or posedge por) begin
      if (por) begin
         q <= 1'b0;
      end else if (load) begin
         q <= wdata;
      end
   end
endmodule

// *** sod_top_asserts.sv ***
`timescale 1ns/1ps
module sod_top_asserts
   import sod_pkg::*;
(
   // Clock, resets and bus
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        POR,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   // Options
   input wire logic        WATCHDOG_ENABLE,
   input wire logic        STOP_PERMIT,
   input wire logic        RESET_PIN_ENABLE,
   input wire logic        RESET_PIN_PULLUP
);
   logic [2:0] age;
   logic       wr0;
   assign wr0 = HSEL && HTRANS[1] && HWRITE && HADDR == SOD_OFS_PRIMARY;
   // Saturates once the lock has had time to reach the outputs
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) age <= 3'h0;
      else if (age != 3'h5 && (age != 3'h0 || wr0)) age <= age + 3'h1;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST || POR);
   sequence s_rd(logic [31:0] a);
      HSEL && HTRANS[1] && !HWRITE && HADDR == a;
   endsequence
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not ready or not okay");
   a_pullup_tracks: assert property (
      RESET_PIN_PULLUP == RESET_PIN_ENABLE)
      else $error("pullup differs from reset pin enable");
   a_rdata_upper: assert property (HRDATA[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_gap_zero: assert property (s_rd(SOD_OFS_PRIMARY) |=>
      HRDATA[3:2] == 2'h0) else $error("unimplemented bits read nonzero");
   a_id_high: assert property (s_rd(SOD_OFS_ID_HIGH) |=>
      HRDATA[7:0] == {SOD_REVISION, SOD_PART_NUMBER[11:8]})
      else $error("bad id high");
   a_id_low: assert property (s_rd(SOD_OFS_ID_LOW) |=>
      HRDATA[7:0] == SOD_PART_NUMBER[7:0]) else $error("bad id low");
   a_reset_vals: assert property ($fell(RST) |->
      WATCHDOG_ENABLE && !STOP_PERMIT)
      else $error("wrong option values at reset");
   a_por_clears: assert property ($fell(POR) |->
      !RESET_PIN_ENABLE) else $error("reset pin enable not cleared");
   a_lock_holds: assert property (age == 3'h5 |->
      $stable({WATCHDOG_ENABLE, STOP_PERMIT, RESET_PIN_ENABLE}))
      else $error("options changed after lock");
endmodule
bind sod_top sod_top_asserts chk_u (.CLK(CLK), .RST(RST), .POR(POR),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .STOP_PERMIT(STOP_PERMIT),
   .RESET_PIN_ENABLE(RESET_PIN_ENABLE), .RESET_PIN_PULLUP(RESET_PIN_PULLUP));

// *** system_options_and_device_id_tb_top.sv ***
`timescale 1ns/1ps
module system_options_and_device_id_tb_top;
   import sod_pkg::*;
   logic        clk = 0, rst = 1, por = 1, hsel = 0, hwrite = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]  htrans = '0;
   logic        rdy, resp, we, wl, wc, sp, dp, re, rp;
   int          fails = 0, n_compared = 0, cyc = 0;
   always #25 clk = ~clk;
   sod_top dut_u (.CLK(clk), .RST(rst), .POR(por), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HREADY(rdy), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(rdy),
      .HRESP(resp), .WATCHDOG_ENABLE(we), .WATCHDOG_LONG_TIMEOUT(wl),
      .WATCHDOG_CLOCK_SELECT(wc), .STOP_PERMIT(sp), .DEBUG_PIN_ENABLE(dp),
      .RESET_PIN_ENABLE(re), .RESET_PIN_PULLUP(rp));
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= SOD_HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= a;
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = hrdata;
   endtask
   task chk_rd(input string n, input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      cmp(n, e, rd);
   endtask
   // Outputs trail the stored value by a fixed one cycle
   task chk_outs(input logic [6:0] e);
      repeat (3) @(posedge clk);
      cmp("outputs", {25'h0, e}, {25'h0, we, wl, sp, dp, re, rp, wc});
   endtask
   task do_reset(input logic p);
      rst <= 1'b1;
      por <= p;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      @(posedge clk);
   endtask
   task t_defaults;
      chk_rd("primary", SOD_OFS_PRIMARY, 32'hD2);
      chk_rd("secondary", SOD_OFS_SECONDARY, 32'h0);
      chk_rd("id_high", SOD_OFS_ID_HIGH, {24'h0, SOD_REVISION,
         SOD_PART_NUMBER[11:8]});
      chk_rd("id_low", SOD_OFS_ID_LOW,
         {24'h0, SOD_PART_NUMBER[7:0]});
      chk_outs(7'h68);
   endtask
   task t_once;
      xfer(1'b1, SOD_OFS_PRIMARY, 32'h2D);
      xfer(1'b1, SOD_OFS_PRIMARY, 32'hC2);
      xfer(1'b1, SOD_OFS_SECONDARY, 32'h1);
      xfer(1'b1, SOD_OFS_SECONDARY, 32'h0);
      xfer(1'b1, SOD_OFS_ID_LOW, 32'hFF);
      chk_rd("primary", SOD_OFS_PRIMARY, 32'h21);
      chk_rd("secondary", SOD_OFS_SECONDARY, 32'h1);
      chk_rd("id_low", SOD_OFS_ID_LOW,
         {24'h0, SOD_PART_NUMBER[7:0]});
      chk_rd("unmapped", 32'h10, 32'h0);
      chk_outs(7'h17);
   endtask
   task t_rst_keep;
      do_reset(1'b0);
      chk_rd("primary", SOD_OFS_PRIMARY, 32'hD3);
      chk_outs(7'h6E);
      do_reset(1'b1);
      // Unmapped write must not take the lock
      xfer(1'b1, 32'h10, 32'h0);
      xfer(1'b1, SOD_OFS_PRIMARY, 32'hD2);
      xfer(1'b1, SOD_OFS_PRIMARY, 32'h00);
      chk_rd("primary", SOD_OFS_PRIMARY, 32'hD2);
      chk_outs(7'h68);
   endtask
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         finish_test;
      end
   end
   initial begin
      do_reset(1'b1);
      t_defaults;
      t_once;
      t_rst_keep;
      finish_test;
   end
endmodule
